// ==== design/dsp_format_pkg.sv ====
// constants, enumerations and carrier structs of the dsp data format unit
package dsp_format_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int GUARD_W = 8;
    // register byte offsets
    localparam logic [7:0] OFS_OPA          = 8'h00;
    localparam logic [7:0] OFS_OPA_GUARD    = 8'h04;
    localparam logic [7:0] OFS_OPB          = 8'h08;
    localparam logic [7:0] OFS_OP           = 8'h0C;
    localparam logic [7:0] OFS_RESULT       = 8'h10;
    localparam logic [7:0] OFS_RESULT_GUARD = 8'h14;
    localparam logic [7:0] OFS_DSP_COND     = 8'h18;
    localparam logic [7:0] OFS_STATUS_WORD  = 8'h1C;
    localparam logic [7:0] OFS_VECTOR_BASE  = 8'h20;
    localparam logic [7:0] OFS_PC           = 8'h24;
    localparam logic [7:0] OFS_SP           = 8'h28;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h2C;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h30;
    localparam logic [7:0] OFS_ENDIAN_CTRL  = 8'h34;
    // status word layout and reset value
    localparam int SW_T_BIT = 0;
    localparam logic [31:0] SW_WMASK = 32'h0FFF_0CF3;
    localparam logic [31:0] SW_RESET = 32'h0000_00F0;
    // dsp condition bits
    localparam int DC_GT = 0;
    localparam int DC_Z = 1;
    localparam int DC_N = 2;
    localparam int DC_V = 3;
    // interrupt status bits
    localparam int IRQ_OVF = 0;
    localparam int IRQ_ADDR_ERR = 1;
    localparam int IRQ_DONE = 2;
    // op register fields
    localparam int OPF_SIZE_LSB = 5;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    // vector table entries and little-endian areas
    localparam logic [31:0] VEC_PC_OFS = 32'h0000_0000;
    localparam logic [31:0] VEC_SP_OFS = 32'h0000_0004;
    localparam logic [2:0] AREA_TWO = 3'h2;
    localparam logic [2:0] AREA_FOUR = 3'h4;
    localparam int AREA_LSB = 26;

    typedef enum logic [4:0] {
        OP_PADD, OP_PSUB, OP_PADD_INT, OP_ARITH_SHIFT, OP_LOGIC_SHIFT, OP_PAND,
        OP_MOVE_IMM, OP_ADD_IMM, OP_COMPARE_EQUAL_IMM, OP_TEST_IMM, OP_AND_IMM,
        OP_OR_IMM, OP_XOR_IMM, OP_LOAD
    } op_code_e;

    typedef enum logic [2:0] {
        BOOT_PC_REQ, BOOT_PC_WAIT, BOOT_SP_REQ, BOOT_SP_WAIT, BOOT_RUN
    } boot_state_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;
endpackage

// ==== design/dsp_format_unit.sv ====
// dsp data format unit: guarded arithmetic, operand extension, loads, reset state
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RQ1 - dsp operations run 40 bits wide: 32-bit value plus 8 guard bits
// RQ2 - overflow flagged when guard bits differ from bit 31 of result
// RQ3 - negative flag is the sign of the full 40-bit result
// RQ4 - results beyond 40 bits wrap; negative flag may then be wrong
// RQ5 - reset: status word mask level all ones, other fields cleared
// RQ6 - reset clears vector base and dsp condition register
// RQ7 - after reset the stack pointer loads from the vector table
// RQ8 - after reset the program counter loads from the vector table
// RQ9 - byte and word loads sign-extend to 32 bits
// RQ10 - misaligned word or longword access raises an address error
// RQ11 - little-endian byte order option for two memory areas
// RQ12 - byte immediate sits in the instruction; wider ones come from memory
// RQ13 - move, add, compare-equal sign-extend the byte immediate
// RQ14 - test and logic ops zero-extend the byte immediate
// RQ15 - fixed-point binary point lies between bits 31 and 30
// RQ16 - integer binary point lies between bits 16 and 15
// RQ17 - arithmetic shift amount 7-bit signed, valid -32 to +32
// RQ18 - logical shift amount 6-bit signed, valid -16 to +16
// RQ19 - logical format is a plain bit pattern without binary point
module dsp_format_unit
    import dsp_format_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    input  wire dsp_format_pkg::bus_req_s bus_req,
    output logic [31:0]                   rd_data,
    output logic                          irq,
    output logic                          vec_req,
    output logic [31:0]                   vec_addr,
    input  wire logic                     vec_valid,
    input  wire logic [31:0]              vec_data,
    output logic                          running
);
    import dsp_format_pkg::*;

    typedef struct packed {
        boot_state_e boot;
        logic        vec_req;
        logic [31:0] vec_addr;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [31:0] vector_base;
        logic [31:0] status_word;
        logic [31:0] opa;
        logic [7:0]  opa_guard;
        logic [31:0] opb;
        logic [31:0] result;
        logic [7:0]  result_guard;
        logic [3:0]  dsp_cond;
        logic [2:0]  irq_status;
        logic [2:0]  irq_mask;
        logic [1:0]  endian_ctrl;
        logic [31:0] rd_data;
        logic        irq;
        logic        running;
    } state_s;

    state_s s_reg;
    state_s s_next;

    // bus decode shared with the checks
    logic     wr_op;
    op_code_e op_code;
    logic [1:0] ld_size;
    logic     misaligned;
    logic     rd_irq;
    assign wr_op = bus_req.wr && (bus_req.addr == OFS_OP);
    assign op_code = op_code_e'(bus_req.wdata[4:0]);
    assign ld_size = bus_req.wdata[OPF_SIZE_LSB +: 2];
    assign rd_irq = bus_req.rd && (bus_req.addr == OFS_IRQ_STATUS);
    // word needs 2n, longword 4n; byte may sit anywhere
    assign misaligned = (ld_size == SIZE_WORD) ? s_reg.opb[0] :
                        (ld_size == SIZE_BYTE) ? 1'b0 : (s_reg.opb[1:0] != 2'h0); // see RQ10

    // next-state logic: boot fetch, register bus, datapath, interrupts
    always_comb begin
        logic [39:0] a40;
        logic [39:0] b40;
        logic [39:0] r40;
        logic [6:0]  amt7;
        logic [5:0]  amt6;
        logic [31:0] u32;
        logic [31:0] sh32;
        logic [31:0] imm_s;
        logic [31:0] imm_z;
        logic [31:0] raw;
        logic [2:0]  ev;
        logic        dsp_upd;
        logic        le;
        a40 = {s_reg.opa_guard, s_reg.opa};
        b40 = {{GUARD_W{s_reg.opb[31]}}, s_reg.opb}; // unguarded source sign-fills guard
        r40 = 40'h00_0000_0000;
        amt7 = s_reg.opb[22:16];
        amt6 = s_reg.opb[21:16];
        u32 = {s_reg.opa[31:16], 16'h0000};
        sh32 = 32'h0000_0000;
        imm_s = {{24{s_reg.opb[7]}}, s_reg.opb[7:0]}; // see RQ12
        imm_z = {24'h00_0000, s_reg.opb[7:0]};
        raw = s_reg.opa;
        ev = 3'h0;
        dsp_upd = 1'b0;
        le = 1'b0;
        s_next = s_reg;
        s_next.vec_req = 1'b0;
        s_next.rd_data = 32'h0000_0000;

        // vector fetch after reset
        unique case (s_reg.boot)
            BOOT_PC_REQ: begin
                s_next.vec_req = 1'b1;
                s_next.vec_addr = s_reg.vector_base + VEC_PC_OFS;
                s_next.boot = BOOT_PC_WAIT;
            end
            BOOT_PC_WAIT: begin
                if (vec_valid) begin
                    s_next.pc = vec_data; // see RQ8
                    s_next.boot = BOOT_SP_REQ;
                end
            end
            BOOT_SP_REQ: begin
                s_next.vec_req = 1'b1;
                s_next.vec_addr = s_reg.vector_base + VEC_SP_OFS;
                s_next.boot = BOOT_SP_WAIT;
            end
            BOOT_SP_WAIT: begin
                if (vec_valid) begin
                    s_next.sp = vec_data; // see RQ7
                    s_next.running = 1'b1;
                    s_next.boot = BOOT_RUN;
                end
            end
            BOOT_RUN: begin
                s_next.boot = BOOT_RUN;
            end
        endcase

        // register writes
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                OFS_OPA:         s_next.opa = bus_req.wdata;
                OFS_OPA_GUARD:   s_next.opa_guard = bus_req.wdata[7:0];
                OFS_OPB:         s_next.opb = bus_req.wdata;
                OFS_DSP_COND:    s_next.dsp_cond = bus_req.wdata[3:0];
                OFS_STATUS_WORD: s_next.status_word = bus_req.wdata & SW_WMASK;
                OFS_VECTOR_BASE: s_next.vector_base = bus_req.wdata;
                OFS_IRQ_MASK:    s_next.irq_mask = bus_req.wdata[2:0];
                OFS_ENDIAN_CTRL: s_next.endian_ctrl = bus_req.wdata[1:0];
                default: ;
            endcase
        end

        // operation issued by a write to the op register
        if (wr_op) begin
            ev[IRQ_DONE] = 1'b1;
            unique case (op_code)
                OP_PADD: begin
                    r40 = a40 + b40; // see RQ1 RQ15
                    dsp_upd = 1'b1;
                end
                OP_PSUB: begin
                    r40 = a40 - b40; // wraps past 40 bits, see RQ4
                    dsp_upd = 1'b1;
                end
                OP_PADD_INT: begin
                    // low word of sources ignored, low word of result cleared
                    r40 = {a40[39:16], 16'h0000} + {b40[39:16], 16'h0000}; // see RQ16
                    r40[15:0] = 16'h0000;
                    dsp_upd = 1'b1;
                end
                OP_ARITH_SHIFT: begin
                    if (amt7[6])
                        r40 = 40'($signed(a40) >>> 7'(~amt7 + 7'h01)); // see RQ17
                    else
                        r40 = a40 << amt7[5:0];
                    dsp_upd = 1'b1;
                end
                OP_LOGIC_SHIFT: begin
                    sh32 = amt6[5] ? (u32 >> 6'(~amt6 + 6'h01)) : (u32 << amt6[4:0]); // see RQ18
                    r40 = {8'h00, sh32[31:16], 16'h0000};
                    dsp_upd = 1'b1;
                end
                OP_PAND: begin
                    // bitwise on upper words, no sign or scale applied
                    r40 = {8'h00, s_reg.opa[31:16] & s_reg.opb[31:16], 16'h0000}; // see RQ19
                    dsp_upd = 1'b1;
                end
                OP_MOVE_IMM: r40 = {{GUARD_W{imm_s[31]}}, imm_s}; // see RQ13
                OP_ADD_IMM:  r40[31:0] = s_reg.opa + imm_s; // see RQ13
                OP_COMPARE_EQUAL_IMM: begin
                    r40[31:0] = s_reg.opa;
                    s_next.status_word[SW_T_BIT] = (s_reg.opa == imm_s); // see RQ13
                end
                OP_TEST_IMM: begin
                    r40[31:0] = s_reg.opa;
                    s_next.status_word[SW_T_BIT] = ((s_reg.opa & imm_z) == 32'h0000_0000); // see RQ14
                end
                OP_AND_IMM: r40[31:0] = s_reg.opa & imm_z; // see RQ14
                OP_OR_IMM:  r40[31:0] = s_reg.opa | imm_z; // see RQ14
                OP_XOR_IMM: r40[31:0] = s_reg.opa ^ imm_z; // see RQ14
                OP_LOAD: begin
                    le = (s_reg.opb[AREA_LSB +: 3] == AREA_TWO && s_reg.endian_ctrl[0]) ||
                         (s_reg.opb[AREA_LSB +: 3] == AREA_FOUR && s_reg.endian_ctrl[1]);
                    if (le && ld_size == SIZE_WORD)
                        raw = {16'h0000, s_reg.opa[7:0], s_reg.opa[15:8]}; // see RQ11
                    else if (le && ld_size != SIZE_BYTE)
                        raw = {s_reg.opa[7:0], s_reg.opa[15:8],
                               s_reg.opa[23:16], s_reg.opa[31:24]}; // see RQ11
                    if (ld_size == SIZE_BYTE)
                        r40[31:0] = {{24{raw[7]}}, raw[7:0]}; // see RQ9
                    else if (ld_size == SIZE_WORD)
                        r40[31:0] = {{16{raw[15]}}, raw[15:0]}; // see RQ9
                    else
                        r40[31:0] = raw;
                    if (misaligned) begin
                        ev[IRQ_ADDR_ERR] = 1'b1; // see RQ10
                        r40 = {s_reg.result_guard, s_reg.result};
                    end
                end
                default: r40 = {s_reg.result_guard, s_reg.result};
            endcase
            s_next.result = r40[31:0];
            // dsp results keep guard; core results fill guard from bit 31
            s_next.result_guard = dsp_upd ? r40[39:32] : {GUARD_W{r40[31]}};
            if (dsp_upd) begin
                s_next.dsp_cond[DC_V] = (r40[39:32] != {GUARD_W{r40[31]}}); // see RQ2
                s_next.dsp_cond[DC_N] = r40[39]; // see RQ3
                s_next.dsp_cond[DC_Z] = (r40 == 40'h00_0000_0000);
                s_next.dsp_cond[DC_GT] = !r40[39] && (r40 != 40'h00_0000_0000);
                ev[IRQ_OVF] = s_next.dsp_cond[DC_V];
            end
        end

        // register reads, answered one cycle later
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFS_OPA:          s_next.rd_data = s_reg.opa;
                OFS_OPA_GUARD:    s_next.rd_data = {24'h00_0000, s_reg.opa_guard};
                OFS_OPB:          s_next.rd_data = s_reg.opb;
                OFS_RESULT:       s_next.rd_data = s_reg.result;
                OFS_RESULT_GUARD: s_next.rd_data = {24'h00_0000, s_reg.result_guard};
                OFS_DSP_COND:     s_next.rd_data = {28'h000_0000, s_reg.dsp_cond};
                OFS_STATUS_WORD:  s_next.rd_data = s_reg.status_word;
                OFS_VECTOR_BASE:  s_next.rd_data = s_reg.vector_base;
                OFS_PC:           s_next.rd_data = s_reg.pc;
                OFS_SP:           s_next.rd_data = s_reg.sp;
                OFS_IRQ_STATUS:   s_next.rd_data = {29'h0000_0000, s_reg.irq_status};
                OFS_IRQ_MASK:     s_next.rd_data = {29'h0000_0000, s_reg.irq_mask};
                OFS_ENDIAN_CTRL:  s_next.rd_data = {30'h0000_0000, s_reg.endian_ctrl};
                default:          s_next.rd_data = 32'h0000_0000;
            endcase
        end

        // sticky events; a same-cycle event survives the read clear
        s_next.irq_status = (rd_irq ? 3'h0 : s_reg.irq_status) | ev;
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);
    end

    // state register with synchronous reset
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s_reg <= '0;
            s_reg.boot <= BOOT_PC_REQ;
            s_reg.status_word <= SW_RESET; // see RQ5
            s_reg.vector_base <= 32'h0000_0000; // see RQ6
            s_reg.dsp_cond <= 4'h0; // see RQ6
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign rd_data = s_reg.rd_data;
    assign irq = s_reg.irq;
    assign vec_req = s_reg.vec_req;
    assign vec_addr = s_reg.vec_addr;
    assign running = s_reg.running;

    // checks
    property p_guard_ovf;
        @(posedge clock) disable iff (!reset_n)
        wr_op && op_code == OP_PADD |=>
            s_reg.dsp_cond[DC_V] == (s_reg.result_guard != {GUARD_W{s_reg.result[31]}});
    endproperty
    a_guard_ovf: assert property (p_guard_ovf) else $error("overflow flag wrong"); // see RQ2

    property p_neg_sign;
        @(posedge clock) disable iff (!reset_n)
        wr_op && (op_code == OP_PSUB || op_code == OP_ARITH_SHIFT) |=>
            s_reg.dsp_cond[DC_N] == s_reg.result_guard[7];
    endproperty
    a_neg_sign: assert property (p_neg_sign) else $error("negative flag wrong"); // see RQ3

    property p_reset_sw;
        @(posedge clock) $rose(reset_n) |-> s_reg.status_word == SW_RESET;
    endproperty
    a_reset_sw: assert property (p_reset_sw) else $error("status word reset wrong"); // see RQ5

    property p_reset_vb;
        @(posedge clock) $rose(reset_n) |-> s_reg.vector_base == 32'h0000_0000 &&
            s_reg.dsp_cond == 4'h0 && s_reg.boot == BOOT_PC_REQ;
    endproperty
    a_reset_vb: assert property (p_reset_vb) else $error("reset values wrong"); // see RQ6

    property p_boot_pc;
        @(posedge clock) disable iff (!reset_n)
        s_reg.boot == BOOT_PC_WAIT && vec_valid |=> s_reg.pc == $past(vec_data) ##1 vec_req;
    endproperty
    a_boot_pc: assert property (p_boot_pc) else $error("pc not loaded"); // see RQ8

    property p_boot_sp;
        @(posedge clock) disable iff (!reset_n)
        s_reg.boot == BOOT_SP_WAIT && vec_valid |=> s_reg.sp == $past(vec_data) && running;
    endproperty
    a_boot_sp: assert property (p_boot_sp) else $error("sp not loaded"); // see RQ7

    property p_load_sext;
        @(posedge clock) disable iff (!reset_n)
        wr_op && op_code == OP_LOAD && ld_size == SIZE_BYTE |=>
            s_reg.result[31:8] == {24{s_reg.result[7]}};
    endproperty
    a_load_sext: assert property (p_load_sext) else $error("byte load not extended"); // see RQ9

    property p_addr_err;
        @(posedge clock) disable iff (!reset_n)
        wr_op && op_code == OP_LOAD && misaligned |=> s_reg.irq_status[IRQ_ADDR_ERR];
    endproperty
    a_addr_err: assert property (p_addr_err) else $error("address error missing"); // see RQ10

    property p_and_imm;
        @(posedge clock) disable iff (!reset_n)
        wr_op && op_code == OP_AND_IMM |=> s_reg.result[31:8] == 24'h00_0000;
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("and immediate upper bits"); // see RQ14

    property p_move_imm;
        @(posedge clock) disable iff (!reset_n)
        wr_op && op_code == OP_MOVE_IMM |=> s_reg.result == {{24{$past(s_reg.opb[7])}},
            $past(s_reg.opb[7:0])};
    endproperty
    a_move_imm: assert property (p_move_imm) else $error("move immediate extension"); // see RQ13

    property p_int_low;
        @(posedge clock) disable iff (!reset_n)
        wr_op && (op_code == OP_PADD_INT || op_code == OP_LOGIC_SHIFT) |=>
            s_reg.result[15:0] == 16'h0000;
    endproperty
    a_int_low: assert property (p_int_low) else $error("low word not cleared"); // see RQ16 RQ18

    property p_irq_level;
        @(posedge clock) disable iff (!reset_n)
        ##1 irq == |(s_reg.irq_status & s_reg.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level mismatch");

    c_boot_done: cover property (@(posedge clock) disable iff (!reset_n) $rose(running));
    c_overflow: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(s_reg.irq_status[IRQ_OVF]));
    c_addr_err: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(s_reg.irq_status[IRQ_ADDR_ERR]));
    c_irq: cover property (@(posedge clock) disable iff (!reset_n) $rose(irq));
endmodule

`default_nettype wire

// ==== tb/dsp_core_data_formats_bench.sv ====
// self-checking bench of the dsp data format unit
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module dsp_core_data_formats_bench;
    import dsp_format_pkg::*;

    localparam logic [31:0] PC_BOOT = 32'h0000_1000;
    localparam logic [31:0] SP_BOOT = 32'h0000_FFF0;

    logic        clock       = 1'b0;
    logic        reset_n     = 1'b0;
    bus_req_s    bus_req     = '0;
    logic [31:0] rd_data;
    logic        irq;
    logic        vec_req;
    logic [31:0] vec_addr;
    logic        vec_valid   = 1'b0;
    logic [31:0] vec_data    = 32'h0;
    logic        running;
    int          n_mismatch  = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    dsp_format_unit u_dut (
        .clock     (clock),
        .reset_n   (reset_n),
        .bus_req   (bus_req),
        .rd_data   (rd_data),
        .irq       (irq),
        .vec_req   (vec_req),
        .vec_addr  (vec_addr),
        .vec_valid (vec_valid),
        .vec_data  (vec_data),
        .running   (running)
    );

    // clock and hang guard
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // closing report
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // register bus cycles, one idle cycle between strobes
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1;
        d = rd_data;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd_reg(a, d);
        `CHECK(d, e)
    endtask

    task automatic run_op(input logic [31:0] a, input logic [7:0] g, input logic [31:0] b,
                          input op_code_e op, input logic [1:0] sz);
        wr_reg(OFS_OPA, a);
        wr_reg(OFS_OPA_GUARD, {24'h0, g});
        wr_reg(OFS_OPB, b);
        wr_reg(OFS_OP, {25'h0, sz, op});
    endtask

    // one vector entry: wait for the request, answer with the entry
    task automatic serve_vec(input logic [31:0] ofs, input logic [31:0] data);
        repeat (10) begin
            @(posedge clock);
            #1;
            if (vec_req === 1'b1) break;
        end
        `CHECK(vec_req, 1'b1)
        `CHECK(vec_addr, ofs)
        @(posedge clock);
        vec_valid <= 1'b1;
        vec_data  <= data;
        @(posedge clock);
        vec_valid <= 1'b0;
        vec_data  <= ~data;
    endtask

    task automatic t_boot();
        serve_vec(VEC_PC_OFS, PC_BOOT);
        serve_vec(VEC_SP_OFS, SP_BOOT);
        repeat (5) begin
            @(posedge clock);
            #1;
            if (running === 1'b1) break;
        end
        `CHECK(running, 1'b1)
        chk_reg(OFS_PC, PC_BOOT);
        chk_reg(OFS_SP, SP_BOOT);
        $display("test boot done");
    endtask

    task automatic t_reset();
        chk_reg(OFS_STATUS_WORD, SW_RESET);
        chk_reg(OFS_VECTOR_BASE, 32'h0);
        chk_reg(OFS_DSP_COND, 32'h0);
        wr_reg(OFS_STATUS_WORD, 32'hFFFF_FFFF);
        chk_reg(OFS_STATUS_WORD, SW_WMASK);
        wr_reg(OFS_STATUS_WORD, SW_RESET);
        wr_reg(OFS_PC, 32'h0000_0BAD);
        chk_reg(OFS_PC, PC_BOOT);
        chk_reg(8'hFC, 32'h0);
        $display("test reset done");
    endtask

    // result, guard and flags of one dsp operation
    task automatic chk_dsp(input logic [31:0] r, input logic [7:0] g, input logic v,
                           input logic n);
        logic [31:0] d;
        chk_reg(OFS_RESULT, r);
        chk_reg(OFS_RESULT_GUARD, {24'h0, g});
        rd_reg(OFS_DSP_COND, d);
        `CHECK(d[DC_V], v)
        `CHECK(d[DC_N], n)
    endtask

    task automatic t_guard();
        logic [31:0] d;
        wr_reg(OFS_IRQ_MASK, 32'h1);
        rd_reg(OFS_IRQ_STATUS, d);
        run_op(32'h7FFF_FFFF, 8'h00, 32'h1, OP_PADD, 2'h0);
        chk_dsp(32'h8000_0000, 8'h00, 1'b1, 1'b0);
        `CHECK(irq, 1'b1)
        chk_reg(OFS_IRQ_STATUS, 32'h5);
        repeat (2) @(posedge clock);
        #1;
        `CHECK(irq, 1'b0)
        run_op(32'h8000_0000, 8'hFF, 32'h1, OP_PSUB, 2'h0);
        chk_dsp(32'h7FFF_FFFF, 8'hFF, 1'b1, 1'b1);
        run_op(32'h0000_0000, 8'h00, 32'h1, OP_PSUB, 2'h0);
        chk_dsp(32'hFFFF_FFFF, 8'hFF, 1'b0, 1'b1);
        $display("test guard done");
    endtask

    task automatic t_fmt();
        run_op(32'h0001_FFFF, 8'h00, 32'h0001_0001, OP_PADD_INT, 2'h0);
        chk_reg(OFS_RESULT, 32'h0002_0000);
        run_op(32'h0000_0001, 8'h00, 32'h0004_0000, OP_ARITH_SHIFT, 2'h0);
        chk_reg(OFS_RESULT, 32'h0000_0010);
        run_op(32'h8000_0000, 8'hFF, 32'h0060_0000, OP_ARITH_SHIFT, 2'h0);
        chk_dsp(32'hFFFF_FFFF, 8'hFF, 1'b0, 1'b1);
        run_op(32'h8000_0000, 8'h00, 32'h0031_0000, OP_LOGIC_SHIFT, 2'h0);
        chk_reg(OFS_RESULT, 32'h0001_0000);
        run_op(32'h4000_0000, 8'h00, 32'h0001_0000, OP_LOGIC_SHIFT, 2'h0);
        chk_reg(OFS_RESULT_GUARD, 32'h0);
        chk_reg(OFS_RESULT, 32'h8000_0000);
        run_op(32'hF0F0_FFFF, 8'h00, 32'hFF00_FFFF, OP_PAND, 2'h0);
        chk_reg(OFS_RESULT, 32'hF000_0000);
        $display("test formats done");
    endtask

    task automatic t_imm();
        run_op(32'h0, 8'h00, 32'h80, OP_MOVE_IMM, 2'h0);
        chk_reg(OFS_RESULT, 32'hFFFF_FF80);
        run_op(32'h1, 8'h00, 32'hFF, OP_ADD_IMM, 2'h0);
        chk_reg(OFS_RESULT, 32'h0);
        run_op(32'hFFFF_FFFF, 8'h00, 32'h80, OP_AND_IMM, 2'h0);
        chk_reg(OFS_RESULT, 32'h80);
        run_op(32'h0, 8'h00, 32'h80, OP_OR_IMM, 2'h0);
        chk_reg(OFS_RESULT, 32'h80);
        run_op(32'hFFFF_FFFF, 8'h00, 32'h80, OP_XOR_IMM, 2'h0);
        chk_reg(OFS_RESULT, 32'hFFFF_FF7F);
        wr_reg(OFS_STATUS_WORD, SW_RESET);
        run_op(32'hFFFF_FF80, 8'h00, 32'h80, OP_COMPARE_EQUAL_IMM, 2'h0);
        chk_reg(OFS_STATUS_WORD, SW_RESET | 32'h1);
        wr_reg(OFS_STATUS_WORD, SW_RESET);
        run_op(32'hFFFF_FF00, 8'h00, 32'hFF, OP_TEST_IMM, 2'h0);
        chk_reg(OFS_STATUS_WORD, SW_RESET | 32'h1);
        $display("test immediates done");
    endtask

    task automatic t_load();
        logic [31:0] d;
        rd_reg(OFS_IRQ_STATUS, d);
        run_op(32'h80, 8'h00, 32'h3, OP_LOAD, SIZE_BYTE);
        chk_reg(OFS_RESULT, 32'hFFFF_FF80);
        run_op(32'h8001, 8'h00, 32'h2, OP_LOAD, SIZE_WORD);
        chk_reg(OFS_RESULT, 32'hFFFF_8001);
        run_op(32'h1234_5678, 8'h00, 32'h6, OP_LOAD, 2'h2);
        chk_reg(OFS_RESULT, 32'hFFFF_8001);
        chk_reg(OFS_IRQ_STATUS, 32'h6);
        wr_reg(OFS_ENDIAN_CTRL, 32'h1);
        run_op(32'h0080, 8'h00, 32'h0800_0000, OP_LOAD, SIZE_WORD);
        chk_reg(OFS_RESULT, 32'hFFFF_8000);
        wr_reg(OFS_ENDIAN_CTRL, 32'h2);
        run_op(32'h7856_3412, 8'h00, 32'h1000_0000, OP_LOAD, 2'h2);
        chk_reg(OFS_RESULT, 32'h1234_5678);
        wr_reg(OFS_OP, 32'h0000_001F);
        chk_reg(OFS_RESULT, 32'h1234_5678);
        $display("test loads done");
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        t_boot();
        t_reset();
        t_guard();
        t_fmt();
        t_imm();
        t_load();
        stop_test();
    end
endmodule

`default_nettype wire
